// ---- rtl/ovs_pkg.sv ----
// Package with register offsets, field layouts, reset values and timing constants.
package ovs_pkg;

  // Register map, byte offsets on the plain register port.
  localparam logic [3:0] CONV_CTRL_OFS = 4'h0;
  localparam logic [3:0] OVS_CTRL_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;
  localparam logic [3:0] RESULT_OFS = 4'hc;

  // Field positions in converter_control_reg_b.
  localparam int POWER_ON_BIT = 0;
  localparam int TEMP_EN_BIT = 1;
  localparam int REF_EN_BIT = 2;

  // Field positions in oversample_control_reg.
  localparam int OVS_EN_BIT = 0;
  localparam int RATIO_LSB = 2;
  localparam int SHIFT_LSB = 5;
  localparam int RES_LSB = 12;

  // Values after reset.
  localparam logic [2:0] CONV_CTRL_RST = 3'h0;
  localparam logic [2:0] RATIO_RST = 3'h0;
  localparam logic [3:0] SHIFT_RST = 4'h0;
  localparam logic [1:0] RES_RST = 2'h0;

  // Internal channel numbers.
  localparam logic [4:0] TEMP_CHANNEL = 5'h10;
  localparam logic [4:0] REF_CHANNEL = 5'h11;

  // Largest shift code accepted.
  localparam logic [3:0] SHIFT_MAX = 4'h8;

  // Minimum sampling phase in half cycles (2.5 clocks), rounded up to whole clocks.
  localparam int SAMPLE_HALF_CYCLES = 5;
  localparam int SAMPLE_CYCLES = (SAMPLE_HALF_CYCLES + 1) / 2;

  // Conversion phase in half cycles per resolution code 12, 10, 8, 6 bits.
  localparam int CONV_HALF_12 = 25;
  localparam int CONV_HALF_10 = 21;
  localparam int CONV_HALF_8 = 17;
  localparam int CONV_HALF_6 = 13;

  // Resolution codes.
  typedef enum logic [1:0] {
    RES_12,
    RES_10,
    RES_8,
    RES_6
  } res_t;

endpackage : ovs_pkg

// ---- rtl/result_buffer.sv ----
// Two-entry valid/ready buffer that carries oversampled results to the reader.
`timescale 1ns/100ps
module result_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count; the count is one bit wider than
  // the pointers so that a full buffer is told apart from an empty one.
  assign in_ready_o = (cnt_q < (PW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_q];

  // Storage is written only on an accepted word.
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule : result_buffer

// ---- rtl/adc_resolution_oversampler.sv ----
// Resolution control, internal channel enables and hardware oversampler of the converter.
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module adc_resolution_oversampler #(
  parameter int ACC_W = 20,
  parameter int OUT_W = 16,
  parameter int RAW_W = 12,
  parameter int BUF_DEPTH = 2
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic [RAW_W-1:0] core_data_i,
  input wire logic core_valid_i,
  output logic core_start_o,
  output logic [1:0] resolution_select_o,
  output logic temp_sensor_power_on_o,
  output logic temp_sensor_channel_o,
  output logic bandgap_ref_channel_o,
  output logic [4:0] temp_channel_num_o,
  output logic [4:0] ref_channel_num_o,
  output logic result_valid_o,
  input wire logic result_ready_i,
  output logic [OUT_W-1:0] result_data_o
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT
  } conv_state_t;

  // Software state.
  logic converter_power_on_q;
  logic temp_sensor_enable_q;
  logic bandgap_ref_enable_q;
  logic ovs_enable_q;
  logic [2:0] oversample_ratio_q;
  logic [3:0] oversample_shift_q;
  logic [1:0] resolution_select_q;
  logic [31:0] rdata_q;

  // Sequencer and oversampler state.
  conv_state_t state_q;
  logic [4:0] phase_cnt_q;
  logic [ACC_W-1:0] acc_q;
  logic [8:0] sample_cnt_q;
  logic [OUT_W-1:0] out_word_q;
  logic out_valid_q;
  logic buf_ready;
  logic [RAW_W-1:0] masked_raw;
  logic sample_take;
  logic last_sample;
  logic [8:0] ratio_n;
  logic [ACC_W-1:0] sum_now;

  // Ratio code to sample count, one doubling per code step.
  function automatic logic [8:0] ratio_count(input logic [2:0] code);
    ratio_count = 9'h002 << code;
  endfunction : ratio_count

  // Conversion length in whole clocks; the half clock is rounded up into this phase.
  function automatic logic [4:0] conv_cycles(input logic [1:0] res);
    int half;
    half = ovs_pkg::CONV_HALF_12;
    case (res)
      ovs_pkg::RES_10: half = ovs_pkg::CONV_HALF_10;
      ovs_pkg::RES_8: half = ovs_pkg::CONV_HALF_8;
      ovs_pkg::RES_6: half = ovs_pkg::CONV_HALF_6;
      default: half = ovs_pkg::CONV_HALF_12;
    endcase
    conv_cycles = 5'((half + 1) / 2);
  endfunction : conv_cycles

  // Round to nearest with the bits shifted out, then keep the low bits only.
  function automatic logic [15:0] shift_round(input logic [19:0] sum, input logic [3:0] sh);
    logic [20:0] biased;
    logic [3:0] s;
    s = (sh > ovs_pkg::SHIFT_MAX) ? ovs_pkg::SHIFT_MAX : sh;
    biased = {1'b0, sum};
    if (s != 4'h0) begin
      biased = biased + (21'h000001 << (s - 4'h1));
    end
    biased = biased >> s;
    shift_round = biased[15:0];
  endfunction : shift_round

  // Register writes. Resolution is ignored while powered, so a running conversion keeps
  // its timing even if software breaks the power-off requirement.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      converter_power_on_q <= ovs_pkg::CONV_CTRL_RST[ovs_pkg::POWER_ON_BIT];
      temp_sensor_enable_q <= ovs_pkg::CONV_CTRL_RST[ovs_pkg::TEMP_EN_BIT];
      bandgap_ref_enable_q <= ovs_pkg::CONV_CTRL_RST[ovs_pkg::REF_EN_BIT];
      ovs_enable_q <= 1'b0;
      oversample_ratio_q <= ovs_pkg::RATIO_RST;
      oversample_shift_q <= ovs_pkg::SHIFT_RST;
      resolution_select_q <= ovs_pkg::RES_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == ovs_pkg::CONV_CTRL_OFS) begin
        converter_power_on_q <= reg_wdata_i[ovs_pkg::POWER_ON_BIT];
        temp_sensor_enable_q <= reg_wdata_i[ovs_pkg::TEMP_EN_BIT];
        bandgap_ref_enable_q <= reg_wdata_i[ovs_pkg::REF_EN_BIT];
      end else if (reg_addr_i == ovs_pkg::OVS_CTRL_OFS) begin
        ovs_enable_q <= reg_wdata_i[ovs_pkg::OVS_EN_BIT];
        oversample_ratio_q <= reg_wdata_i[ovs_pkg::RATIO_LSB +: 3];
        oversample_shift_q <= reg_wdata_i[ovs_pkg::SHIFT_LSB +: 4];
        if (!converter_power_on_q) begin
          resolution_select_q <= reg_wdata_i[ovs_pkg::RES_LSB +: 2];
        end
      end
    end
  end

  // Read data stand for the one cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      if (reg_addr_i == ovs_pkg::CONV_CTRL_OFS) begin
        rdata_q <= {29'h0, bandgap_ref_enable_q, temp_sensor_enable_q, converter_power_on_q};
      end else if (reg_addr_i == ovs_pkg::OVS_CTRL_OFS) begin
        rdata_q <= {18'h0, resolution_select_q, 3'h0, oversample_shift_q,
                    oversample_ratio_q, 1'b0, ovs_enable_q};
      end else if (reg_addr_i == ovs_pkg::STATUS_OFS) begin
        rdata_q <= {14'h0, state_q, 7'h0, sample_cnt_q};
      end else if (reg_addr_i == ovs_pkg::RESULT_OFS) begin
        rdata_q <= {15'h0, result_valid_o, result_data_o};
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end
  assign reg_rdata_o = rdata_q;

  // Internal channel routing follows the enables directly.
  assign temp_sensor_power_on_o = temp_sensor_enable_q;
  assign temp_sensor_channel_o = temp_sensor_enable_q;
  assign bandgap_ref_channel_o = bandgap_ref_enable_q;
  assign temp_channel_num_o = ovs_pkg::TEMP_CHANNEL;
  assign ref_channel_num_o = ovs_pkg::REF_CHANNEL;
  assign resolution_select_o = resolution_select_q;

  // Conversion sequencer: fixed sampling phase, then a resolution-dependent conversion
  // phase. It holds in idle while a finished word waits to enter the buffer, so no result is overwritten.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      phase_cnt_q <= 5'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (converter_power_on_q && !out_valid_q) begin
            state_q <= ST_SAMPLE;
            phase_cnt_q <= 5'(ovs_pkg::SAMPLE_CYCLES - 1);
          end
        end
        ST_SAMPLE: begin
          if (phase_cnt_q == 5'h00) begin
            state_q <= ST_CONVERT;
            phase_cnt_q <= conv_cycles(resolution_select_q) - 5'h01;
          end else begin
            phase_cnt_q <= phase_cnt_q - 5'h01;
          end
        end
        ST_CONVERT: begin
          if (phase_cnt_q == 5'h00) begin
            state_q <= ST_IDLE;
          end else begin
            phase_cnt_q <= phase_cnt_q - 5'h01;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  assign core_start_o = (state_q == ST_SAMPLE) && (phase_cnt_q == 5'(ovs_pkg::SAMPLE_CYCLES - 1));

  // Low bits below the selected resolution are forced to zero.
  always_comb begin
    masked_raw = core_data_i;
    case (resolution_select_q)
      ovs_pkg::RES_10: masked_raw = {core_data_i[RAW_W-1:2], 2'b00};
      ovs_pkg::RES_8: masked_raw = {core_data_i[RAW_W-1:4], 4'h0};
      ovs_pkg::RES_6: masked_raw = {core_data_i[RAW_W-1:6], 6'h00};
      default: masked_raw = core_data_i;
    endcase
  end

  assign sample_take = core_valid_i && !out_valid_q;
  assign ratio_n = ratio_count(oversample_ratio_q);
  assign last_sample = !ovs_enable_q || (sample_cnt_q == ratio_n - 9'h001);
  assign sum_now = acc_q + ACC_W'(masked_raw);

  // Accumulator: sums N results, then restarts from zero for the next group.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_q <= '0;
      sample_cnt_q <= 9'h000;
    end else if (!ovs_enable_q) begin
      acc_q <= '0;
      sample_cnt_q <= 9'h000;
    end else if (sample_take) begin
      if (last_sample) begin
        acc_q <= '0;
        sample_cnt_q <= 9'h000;
      end else begin
        acc_q <= sum_now;
        sample_cnt_q <= sample_cnt_q + 9'h001;
      end
    end
  end

  // Output word: one per N conversions, or every conversion when oversampling is off.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_word_q <= '0;
      out_valid_q <= 1'b0;
    end else if (sample_take && last_sample) begin
      out_valid_q <= 1'b1;
      if (ovs_enable_q) begin
        out_word_q <= shift_round(sum_now, oversample_shift_q);
      end else begin
        out_word_q <= OUT_W'(masked_raw);
      end
    end else if (buf_ready) begin
      out_valid_q <= 1'b0;
    end
  end

  // Two-entry buffer toward the result reader; a stalled reader stalls the sequencer.
  result_buffer #(
    .WIDTH(OUT_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(out_valid_q),
    .in_ready_o(buf_ready),
    .in_data_i(out_word_q),
    .out_valid_o(result_valid_o),
    .out_ready_i(result_ready_i),
    .out_data_o(result_data_o)
  );

  // Checks.
  chk_sensor_route: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    temp_sensor_power_on_o == temp_sensor_enable_q && temp_sensor_channel_o == temp_sensor_power_on_o)
    else $error("sensor routing wrong");
  chk_ref_route: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(bandgap_ref_enable_q) |-> bandgap_ref_channel_o)
    else $error("bandgap not routed");
  chk_res_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $past(converter_power_on_q) |-> $stable(resolution_select_q))
    else $error("resolution changed while powered");
  chk_low_bits: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    resolution_select_q == ovs_pkg::RES_6 |-> masked_raw[5:0] == 6'h00)
    else $error("low bits not zero");
  sequence s_sample_done;
    state_q == ST_SAMPLE && phase_cnt_q == 5'h00 && resolution_select_q == ovs_pkg::RES_12;
  endsequence
  chk_conv_len: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_sample_done |=> (state_q == ST_CONVERT) [*8] ##1 (state_q == ST_CONVERT) [*5]
    ##1 state_q == ST_IDLE)
    else $error("conversion length wrong");
  chk_ratio_map: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    oversample_ratio_q == 3'h7 |-> ratio_n == 9'h100)
    else $error("ratio mapping wrong");
  chk_acc_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    sample_take && last_sample |=> acc_q == '0 && out_valid_q)
    else $error("accumulator not cleared");
  chk_group_count: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ovs_enable_q |-> sample_cnt_q < ratio_n)
    else $error("group count overrun");
  chk_round_out: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    sample_take && last_sample && ovs_enable_q && oversample_shift_q == 4'h0
    |=> out_word_q == $past(sum_now[15:0]))
    else $error("unshifted result not truncated");

endmodule : adc_resolution_oversampler

// ---- bench/conv_core_model.sv ----
// Behavioural model of the analogue converter core that feeds the oversampler.
`timescale 1ns/100ps
module conv_core_model (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [1:0] res_i,
  input wire logic [11:0] base_i,
  input wire logic step_i,
  output logic valid_o,
  output logic [11:0] data_o
);
  int cnt_q;
  logic [11:0] idx_q;

  // Counts out three sampling clocks plus the conversion phase of the resolution in use.
  // Every conversion has the same sampling time, whatever the oversampling setting.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 0;
    end else if (start_i) begin
      cnt_q <= 3 + 13 - 2 * int'(res_i) - 2;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end
  end

  // The finished word arrives in the last conversion cycle, low bits cleared at reduced
  // resolution; between words the line toggles so a stale value is never mistaken for data.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      valid_o <= 1'b0;
      data_o <= 12'h000;
      idx_q <= 12'h000;
    end else if (cnt_q == 1 && !start_i) begin
      valid_o <= 1'b1;
      data_o <= (base_i + (step_i ? idx_q : 12'h000)) & (12'hfff << (2 * res_i));
      idx_q <= idx_q + 12'h001;
    end else begin
      valid_o <= 1'b0;
      data_o <= ~data_o;
    end
  end
endmodule : conv_core_model

// ---- bench/tb.sv ----
// Self-checking testbench for the resolution control and oversampler.
`timescale 1ns/100ps
module tb;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [11:0] core_data_i;
  logic core_valid_i;
  logic core_start_o;
  logic [1:0] resolution_select_o;
  logic temp_sensor_power_on_o;
  logic temp_sensor_channel_o;
  logic bandgap_ref_channel_o;
  logic [4:0] temp_channel_num_o;
  logic [4:0] ref_channel_num_o;
  logic result_valid_o;
  logic result_ready_i = 1'b1;
  logic [15:0] result_data_o;
  logic [11:0] sample_base = 12'h000;
  logic sample_step = 1'b0;
  int mismatches = 0;
  int checked = 0;
  int samples = 0;
  int gap = 0;
  int since = 0;
  logic [31:0] rd;
  logic [15:0] got;
  int cnt;

  adc_resolution_oversampler dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .core_data_i(core_data_i),
    .core_valid_i(core_valid_i), .core_start_o(core_start_o),
    .resolution_select_o(resolution_select_o), .temp_sensor_power_on_o(temp_sensor_power_on_o),
    .temp_sensor_channel_o(temp_sensor_channel_o), .bandgap_ref_channel_o(bandgap_ref_channel_o),
    .temp_channel_num_o(temp_channel_num_o), .ref_channel_num_o(ref_channel_num_o),
    .result_valid_o(result_valid_o), .result_ready_i(result_ready_i),
    .result_data_o(result_data_o));

  conv_core_model core_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .start_i(core_start_o),
    .res_i(resolution_select_o), .base_i(sample_base), .step_i(sample_step),
    .valid_o(core_valid_i), .data_o(core_data_i));

  // Free-running converter clock of 50 ns.
  always #25 ref_clk_i = ~ref_clk_i;

  // Counts samples handed over and measures the spacing of conversion starts.
  always @(negedge ref_clk_i) begin
    if (core_valid_i === 1'b1) begin
      samples++;
    end
    since++;
    if (core_start_o === 1'b1) begin
      gap = since;
      since = 0;
    end
  end

  task automatic compare(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : compare

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    // Step past the edge so that callers see the state the write has just produced.
    #1;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe, so they are taken right there.
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask : reg_read

  task automatic do_reset();
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    // Samples of the run before the reset belong to no result of the next scenario.
    samples = 0;
  endtask : do_reset

  // Waits a bounded time for a result and reports how many samples went into it.
  task automatic get_result(output logic [15:0] d, output int n);
    for (int i = 0; i < 6000; i++) begin
      @(negedge ref_clk_i);
      #1;
      if (result_valid_o === 1'b1) begin
        d = result_data_o;
        n = samples;
        samples = 0;
        return;
      end
    end
    mismatches++;
    $display("unexpected result_valid_o: expected 1, seen 0");
    d = 16'h0;
    n = 0;
  endtask : get_result

  // Two consecutive oversampled results from a constant input must both match the model sum.
  task automatic run_ovs(input logic [2:0] r, input logic [3:0] s, input logic [11:0] v);
    int n;
    int sh;
    int acc;
    logic [15:0] exp;
    do_reset();
    sample_base <= v;
    sample_step <= 1'b0;
    n = 2 << r;
    sh = (s > 4'h8) ? 8 : int'(s);
    acc = n * int'(v) + ((sh == 0) ? 0 : (1 << (sh - 1)));
    exp = 16'(acc >> sh);
    reg_write(4'h4, {23'h0, s, r, 1'b0, 1'b1});
    reg_write(4'h0, 32'h1);
    for (int k = 0; k < 2; k++) begin
      get_result(got, cnt);
      compare("ovs result", got, exp);
      compare("samples per result", cnt, n);
    end
  endtask : run_ovs

  initial begin
    do_reset();
    // Register and channel state after reset; an unmapped place takes no write.
    reg_write(4'h1, 32'hffff_ffff);
    reg_read(4'h1, rd);
    compare("unmapped read", rd, 32'h0);
    reg_read(4'h4, rd);
    compare("ovs ctrl reset", rd, 32'h0);
    compare("temp channel number", temp_channel_num_o, 5'h10);
    compare("ref channel number", ref_channel_num_o, 5'h11);
    compare("sensor power reset", temp_sensor_power_on_o, 1'b0);
    // No temperature reading is trusted here: the clock is above the sensor limit, and the
    // first three results after enabling would be discarded anyway.
    reg_write(4'h0, 32'h2);
    compare("sensor power", temp_sensor_power_on_o, 1'b1);
    compare("sensor channel", temp_sensor_channel_o, 1'b1);
    reg_write(4'h0, 32'h4);
    compare("sensor power down", temp_sensor_power_on_o, 1'b0);
    compare("bandgap channel", bandgap_ref_channel_o, 1'b1);
    reg_read(4'h0, rd);
    compare("conv ctrl readback", rd, 32'h4);
    // Resolution is set with power off; a change while powered is ignored.
    reg_write(4'h4, 32'h2000);
    reg_write(4'h0, 32'h1);
    reg_write(4'h4, 32'h3000);
    compare("resolution held", resolution_select_o, 2'h2);
    // Plain conversions at each resolution: width, low bits and conversion spacing.
    for (int res = 0; res < 4; res++) begin
      do_reset();
      sample_base <= 12'habc;
      reg_write(4'h4, 32'(res) << 12);
      reg_write(4'h0, 32'h1);
      get_result(got, cnt);
      compare("plain result", got, 16'(12'habc & (12'hfff << (2 * res))));
      get_result(got, cnt);
      // Starts are three sampling clocks, 13 - 2 * res conversion clocks, one idle clock and
      // one clock in which the finished word is handed to the buffer apart.
      compare("start spacing", gap, 18 - 2 * res);
    end
    // Every ratio code, shift codes 0 to 8, truncation, rounding and an oversized shift code.
    for (int r = 0; r < 8; r++) begin
      run_ovs(3'(r), 4'(r), 12'hfff);
    end
    run_ovs(3'h7, 4'h0, 12'hfff);
    run_ovs(3'h4, 4'h8, 12'hfff);
    run_ovs(3'h0, 4'h2, 12'h801);
    run_ovs(3'h1, 4'h9, 12'hfff);
    // A stalled reader must lose no word: the counting input shows any gap.
    do_reset();
    sample_base <= 12'h000;
    sample_step <= 1'b1;
    result_ready_i <= 1'b0;
    reg_write(4'h0, 32'h1);
    repeat (120) @(posedge ref_clk_i);
    compare("buffer holds", result_valid_o, 1'b1);
    result_ready_i <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      get_result(got, cnt);
      compare("buffered word", got, 16'(i));
    end
    end_sim();
  end

  // Cuts a hang short well after the longest expected run.
  initial begin
    #(50 * 60000);
    mismatches++;
    end_sim();
  end

  task automatic end_sim();
    if (mismatches == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
endmodule : tb
